// ---- verilog/wkmon_defines.svh ----
`ifndef WKMON_DEFINES_SVH
`define WKMON_DEFINES_SVH

// filter times in microseconds and derived cycle counts at 20 MHz
`define WKMON_CLK_MHZ      20
`define WKMON_FLT_SHORT_US 16
`define WKMON_FLT_LONG_US  64
`define WKMON_FLT_SHORT_CY (`WKMON_FLT_SHORT_US * `WKMON_CLK_MHZ)
`define WKMON_FLT_LONG_CY  (`WKMON_FLT_LONG_US * `WKMON_CLK_MHZ)
`define WKMON_CNT_W        11
// channel counts
`define WKMON_NUM_WK       3
`define WKMON_NUM_ALT      2
// bias field codes
`define WKMON_BIAS_NONE    2'h0
`define WKMON_BIAS_DOWN    2'h1
`define WKMON_BIAS_UP      2'h2
`define WKMON_BIAS_AUTO    2'h3
// detection field codes
`define WKMON_DET_S16      2'h0
`define WKMON_DET_S64      2'h1
`define WKMON_DET_CYC1     2'h2
`define WKMON_DET_CYC2     2'h3
// reset values
`define WKMON_BIAS_RST     6'h00
`define WKMON_DET_RST      6'h00
`define WKMON_EN_RST       3'h0

`endif

// ---- verilog/wkmon_pkg.sv ----
package wkmon_pkg;

  // operating modes of the surrounding device
  typedef enum logic [1:0] {
    WKMON_MODE_NORMAL   = 2'h0,
    WKMON_MODE_STOP     = 2'h1,
    WKMON_MODE_SLEEP    = 2'h2,
    WKMON_MODE_FAILSAFE = 2'h3
  } wkmon_mode_t;

  // per-pin configuration from the control port
  typedef struct packed {
    logic [5:0] input_bias_control;
    logic [5:0] detection_filter_control;
    logic [2:0] wake_enable_control;
  } wkmon_cfg_t;

  // bias drive outputs, one bit per pin
  typedef struct packed {
    logic [2:0] pull_up;
    logic [2:0] pull_down;
  } wkmon_bias_t;

endpackage

// ---- verilog/wkmon_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for asynchronous pin levels
module wkmon_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = ce_i ? async_i : meta_q;
    sync_d = ce_i ? meta_q : sync_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// ---- verilog/wkmon_filter.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "wkmon_defines.svh"
// edge deglitch: accepts a new level once it held for the filter time
module wkmon_filter #(
  parameter int CW = `WKMON_CNT_W
) (
  input  wire logic          sys_clk_i,
  input  wire logic          srst_i,
  input  wire logic          ce_i,
  input  wire logic          level_i,
  input  wire logic          active_i,
  input  wire logic [CW-1:0] limit_i,
  output logic               level_o,
  output logic               edge_o
);
  import wkmon_pkg::*;

  logic          stable_q;
  logic          stable_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          edge_q;
  logic          edge_d;

  // timer restarts whenever the input falls back to the accepted level
  // R7 - restart on return
  always_comb begin
    stable_d = stable_q;
    cnt_d    = cnt_q;
    edge_d   = 1'b0;
    if (!active_i || level_i == stable_q) begin
      cnt_d = '0;
    end else if (cnt_q >= limit_i - CW'(1)) begin
      stable_d = level_i;
      cnt_d    = '0;
      edge_d   = 1'b1;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      stable_q <= 1'b0;
      cnt_q    <= '0;
      edge_q   <= 1'b0;
    end else if (ce_i) begin
      stable_q <= stable_d;
      cnt_q    <= cnt_d;
      edge_q   <= edge_d;
    end
  end

  assign level_o = stable_q;
  assign edge_o  = edge_q;
endmodule
`default_nettype wire

// ---- verilog/wkmon_top.sv ----
// Summary of operation
// R1 - three wake channels processed independently
// R2 - rising and falling edges both signal
// R3 - interrupt in normal/stop, wake in sleep
// R4 - per pin static or cyclic sensing
// R5 - cyclic sensing gated by timer one/two
// R6 - static filter selectable 16 or 64 us
// R7 - wake only if level holds filter time
// R8 - per pin wake enable bit
// R9 - three latched wake source bits readable
// R10 - live pin levels in normal and stop
// R11 - cyclic pins report last sampled level
// R12 - fail pins: fixed 16 us, second status
// R13 - pull-up and pull-down sources per pin
// R14 - bias codes: none, down, up, automatic
// R15 - detect codes: s16, s64, cyc1, cyc2
// R16 - status sticky until software clears
`timescale 1ns/100ps
`default_nettype none
`include "wkmon_defines.svh"
module wkmon_top #(
  parameter int NWK = `WKMON_NUM_WK,
  parameter int NFO = `WKMON_NUM_ALT
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   ce_i,
  input  wire logic [NWK-1:0]         wake_input_pin_i,
  input  wire logic [NFO-1:0]         fail_output_pins_i,
  input  wire logic                   fail_pins_as_wake_i,
  input  wire logic                   cyclic_timer_one_i,
  input  wire logic                   cyclic_timer_two_i,
  input  wire wkmon_pkg::wkmon_mode_t mode_i,
  input  wire wkmon_pkg::wkmon_cfg_t  cfg_i,
  input  wire logic [NWK-1:0]         status_clr_i,
  input  wire logic [NFO-1:0]         alt_status_clr_i,
  output logic [NWK-1:0]              wake_source_status_o,
  output logic [NFO-1:0]              alt_wake_source_status_o,
  output logic [NWK-1:0]              pin_level_status_o,
  output wkmon_pkg::wkmon_bias_t      bias_o,
  output logic                        irq_o,
  output logic                        wake_req_o
);
  import wkmon_pkg::*;

  localparam int CW = `WKMON_CNT_W;
  localparam logic [CW-1:0] FLT_SHORT = CW'(`WKMON_FLT_SHORT_CY);
  localparam logic [CW-1:0] FLT_LONG  = CW'(`WKMON_FLT_LONG_CY);

  // decode a pin's two-bit detection field
  function automatic logic [1:0] det_of(input logic [5:0] f, input int i);
    det_of = f[2*i +: 2];
  endfunction

  logic [NWK-1:0] wk_sync;
  logic [NFO-1:0] fo_sync;
  logic [1:0]     tmr_sync;
  logic [NWK-1:0] wk_lvl;
  logic [NWK-1:0] wk_edge;
  logic [NWK-1:0] wk_act;
  logic [NWK-1:0] wk_cyc;
  logic [NFO-1:0] fo_edge;
  logic [1:0]     tmr_q;
  logic [1:0]     tmr_d;
  logic [NWK-1:0] stat_q;
  logic [NWK-1:0] stat_d;
  logic [NFO-1:0] alt_q;
  logic [NFO-1:0] alt_d;
  logic [NWK-1:0] samp_q;
  logic [NWK-1:0] samp_d;
  logic [NWK-1:0] lvl_q;
  logic [NWK-1:0] lvl_d;
  logic [NWK-1:0] pu_q;
  logic [NWK-1:0] pu_d;
  logic [NWK-1:0] pd_q;
  logic [NWK-1:0] pd_d;
  logic           irq_q;
  logic           irq_d;
  logic           wake_q;
  logic           wake_d;
  logic           low_power;
  logic           any_new;

  // pins and timer strobes are asynchronous to this clock
  wkmon_sync #(.W(NWK)) u_sync_wk (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .async_i   (wake_input_pin_i),
    .sync_o    (wk_sync)
  );
  wkmon_sync #(.W(NFO)) u_sync_fo (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .async_i   (fail_output_pins_i),
    .sync_o    (fo_sync)
  );
  wkmon_sync #(.W(2)) u_sync_tmr (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .async_i   ({cyclic_timer_two_i, cyclic_timer_one_i}),
    .sync_o    (tmr_sync)
  );

  // R1 - one filter per channel
  for (genvar i = 0; i < NWK; i++) begin : g_wk
    logic [1:0] det;
    assign det = det_of(cfg_i.detection_filter_control, i);
    // R4 - cyclic pins active only in timer on-time
    // R5 - timer one or two picks the window
    assign wk_cyc[i] = det[1];
    assign wk_act[i] = !det[1] ||
                       (det[0] ? tmr_sync[1] : tmr_sync[0]);
    // R6 - static 64 us only for code s64
    // R15 - cyclic codes use short filter
    wkmon_filter #(.CW(CW)) u_flt (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .level_i   (wk_sync[i]),
      .active_i  (wk_act[i]),
      .limit_i   ((det == `WKMON_DET_S64) ? FLT_LONG : FLT_SHORT),
      .level_o   (wk_lvl[i]),
      .edge_o    (wk_edge[i])
    );
  end

  // R12 - fail pins use fixed short static filter
  for (genvar j = 0; j < NFO; j++) begin : g_fo
    wkmon_filter #(.CW(CW)) u_flt (
      .sys_clk_i (sys_clk_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .level_i   (fo_sync[j]),
      .active_i  (fail_pins_as_wake_i),
      .limit_i   (FLT_SHORT),
      .level_o   (),
      .edge_o    (fo_edge[j])
    );
  end

  assign low_power = (mode_i == WKMON_MODE_SLEEP) ||
                     (mode_i == WKMON_MODE_FAILSAFE);
  // R8 - only enabled pins count as wake sources
  assign any_new = |(wk_edge & cfg_i.wake_enable_control) ||
                   (fail_pins_as_wake_i && |fo_edge);

  // status, levels, bias and signalling next values
  always_comb begin
    tmr_d  = tmr_sync;
    // R2 - filter edge flags both directions
    // R9 - latch source bit per pin
    // R16 - set wins over software clear
    stat_d = (stat_q & ~status_clr_i) |
             (wk_edge & cfg_i.wake_enable_control);
    alt_d  = (alt_q & ~alt_status_clr_i) |
             (fail_pins_as_wake_i ? fo_edge : '0);
    samp_d = samp_q;
    pu_d   = pu_q;
    pd_d   = pd_q;
    for (int k = 0; k < NWK; k++) begin
      // R11 - capture at end of timer on-time
      if (wk_cyc[k] && !wk_act[k] &&
          (tmr_q[det_of(cfg_i.detection_filter_control, k) == 2'h3]))
        samp_d[k] = wk_lvl[k];
      // R13 - per pin current sources
      // R14 - bias code decode
      case (cfg_i.input_bias_control[2*k +: 2])
        `WKMON_BIAS_NONE: begin
          pu_d[k] = 1'b0;
          pd_d[k] = 1'b0;
        end
        `WKMON_BIAS_DOWN: begin
          pu_d[k] = 1'b0;
          pd_d[k] = 1'b1;
        end
        `WKMON_BIAS_UP: begin
          pu_d[k] = 1'b1;
          pd_d[k] = 1'b0;
        end
        default: begin
          pu_d[k] = wk_sync[k];
          pd_d[k] = !wk_sync[k];
        end
      endcase
    end
    // R10 - level readback, frozen in low power
    lvl_d = low_power ? lvl_q :
            ((wk_cyc & samp_d) | (~wk_cyc & wk_sync));
    // R3 - interrupt when awake, wake when asleep
    irq_d  = any_new && !low_power;
    wake_d = any_new && low_power;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tmr_q  <= 2'h0;
      stat_q <= `WKMON_EN_RST;
      alt_q  <= '0;
      samp_q <= '0;
      lvl_q  <= '0;
      pu_q   <= '0;
      pd_q   <= '0;
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else if (ce_i) begin
      tmr_q  <= tmr_d;
      stat_q <= stat_d;
      alt_q  <= alt_d;
      samp_q <= samp_d;
      lvl_q  <= lvl_d;
      pu_q   <= pu_d;
      pd_q   <= pd_d;
      irq_q  <= irq_d;
      wake_q <= wake_d;
    end
  end

  assign wake_source_status_o     = stat_q;
  assign alt_wake_source_status_o = alt_q;
  assign pin_level_status_o       = lvl_q;
  assign bias_o.pull_up           = pu_q;
  assign bias_o.pull_down         = pd_q;
  assign irq_o                    = irq_q;
  assign wake_req_o               = wake_q;

  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_irq_awake_only: assert property ( // R3
    irq_o |-> $past(!low_power)) else $error("irq in low power");
  a_wake_lowpower: assert property ( // R3
    wake_req_o |-> $past(low_power)) else $error("wake while awake");
  a_stat_sticky: assert property ( // R16
    (ce_i && stat_q[0] && !status_clr_i[0]) |=> stat_q[0])
    else $error("status bit lost");
  a_stat_enable: assert property ( // R8
    (ce_i && $rose(stat_q[0]) == 1'b0 && !stat_q[0] &&
     wk_edge[0] && cfg_i.wake_enable_control[0]) |=> stat_q[0])
    else $error("enabled edge not latched");
  a_stat_blocked: assert property ( // R9
    (ce_i && !stat_q[1] && !(wk_edge[1] &&
     cfg_i.wake_enable_control[1])) |=> !stat_q[1])
    else $error("status set without cause");
  a_bias_down: assert property ( // R14
    (ce_i && cfg_i.input_bias_control[1:0] == `WKMON_BIAS_DOWN)
    |=> (bias_o.pull_down[0] && !bias_o.pull_up[0]))
    else $error("pull-down decode wrong");
  a_bias_auto: assert property ( // R13
    (ce_i && cfg_i.input_bias_control[1:0] == `WKMON_BIAS_AUTO)
    |=> (bias_o.pull_up[0] == $past(wk_sync[0])))
    else $error("auto bias wrong");
  a_alt_gated: assert property ( // R12
    (ce_i && !fail_pins_as_wake_i && !alt_q[0]) |=> !alt_q[0])
    else $error("alt status without alt role");
  a_level_live: assert property ( // R10
    (ce_i && !low_power && !wk_cyc[2]) |=> pin_level_status_o[2] ==
    $past(wk_sync[2])) else $error("live level wrong");

  // every accepted edge flips the level, whichever way it went
  a_edge_flips: assert property ( // R2
    (ce_i && $past(ce_i) && wk_edge[0]) |->
    (wk_lvl[0] != $past(wk_lvl[0]))) else $error("edge kept level");
  // enabled edges signal according to the mode
  a_irq_cause: assert property ( // R3
    (ce_i && !low_power && wk_edge[2] && cfg_i.wake_enable_control[2])
    |=> irq_o) else $error("enabled edge gave no irq");
  a_wake_cause: assert property ( // R3
    (ce_i && low_power && wk_edge[0] && cfg_i.wake_enable_control[0])
    |=> wake_req_o) else $error("enabled edge gave no wake");
  // cyclic pins stay deaf between on-times
  a_cyc_ignored: assert property ( // R4
    (ce_i && wk_cyc[2] && !wk_act[2]) |=> !wk_edge[2])
    else $error("cyclic edge outside on-time");
  a_cyc_sample: assert property ( // R11
    (ce_i && !low_power && wk_cyc[2] && !wk_act[2] &&
     tmr_q[det_of(cfg_i.detection_filter_control, 2) == 2'h3])
    |=> (pin_level_status_o[2] == $past(wk_lvl[2])))
    else $error("sampled level not shown");
  a_level_frozen: assert property ( // R10
    (ce_i && low_power) |=> $stable(pin_level_status_o))
    else $error("level readback moved in low power");
  a_alt_latch: assert property ( // R12
    (ce_i && fail_pins_as_wake_i && fo_edge[0]) |=> alt_q[0])
    else $error("alt edge not latched");
  // remaining bias codes, checked on the other pins
  a_bias_up: assert property ( // R14
    (ce_i && cfg_i.input_bias_control[3:2] == `WKMON_BIAS_UP)
    |=> (bias_o.pull_up[1] && !bias_o.pull_down[1]))
    else $error("pull-up decode wrong");
  a_bias_none: assert property ( // R14
    (ce_i && cfg_i.input_bias_control[5:4] == `WKMON_BIAS_NONE)
    |=> (!bias_o.pull_up[2] && !bias_o.pull_down[2]))
    else $error("no-bias decode wrong");

  c_irq: cover property (irq_o);
  c_wake: cover property (wake_req_o);
  c_alt: cover property (|alt_wake_source_status_o);
  c_cyc: cover property (wk_cyc[2] && wk_edge[2]);
  c_stop_irq: cover property (irq_o && mode_i == WKMON_MODE_STOP);
endmodule
`default_nettype wire

// ---- verification/wkmon_pins_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// outside switches on the wake pins; optional contact bounce on changes
module wkmon_pins_model (
  input  wire logic       sys_clk_i,
  input  wire logic [2:0] lvl_i,
  input  wire logic       bounce_i,
  output logic      [2:0] pin_o
);
  logic [2:0] prev_q = 3'h0;
  logic [3:0] cnt_q  = 4'h0;
  logic [2:0] msk_q  = 3'h0;

  // a changed level chatters ten cycles, far below any filter time
  always_ff @(posedge sys_clk_i) begin
    prev_q <= lvl_i;
    if (lvl_i != prev_q && bounce_i) begin
      cnt_q <= 4'hA;
      msk_q <= lvl_i ^ prev_q;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // chatter shows the inverse level on odd counts, only on changed pins
  assign pin_o = lvl_i ^ ({3{cnt_q[0]}} & msk_q);
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "wkmon_defines.svh"
module tb;
  import wkmon_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic        ce_i      = 1'b1;
  logic        role_q    = 1'b0;
  logic        t1_q      = 1'b0;
  logic        t2_q      = 1'b0;
  logic        bnc_q     = 1'b0;
  logic [2:0]  lvl_q     = 3'h0;
  logic [2:0]  clr_q     = 3'h0;
  logic [1:0]  fo_q      = 2'h0;
  logic [1:0]  aclr_q    = 2'h0;
  logic [16:0] rnd       = 17'h11F03;
  wkmon_mode_t mode_q    = WKMON_MODE_NORMAL;
  wkmon_cfg_t  cfg_q     = '0;
  logic [2:0]  pin, st, lv;
  logic [1:0]  ast;
  wkmon_bias_t bias;
  logic        irq, wrq;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n, k;

  wkmon_pins_model i_wkmon_pins_model (.sys_clk_i(sys_clk_i), .lvl_i(lvl_q),
    .bounce_i(bnc_q), .pin_o(pin));

  wkmon_top i_wkmon_top (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .wake_input_pin_i(pin), .fail_output_pins_i(fo_q),
    .fail_pins_as_wake_i(role_q), .cyclic_timer_one_i(t1_q),
    .cyclic_timer_two_i(t2_q), .mode_i(mode_q), .cfg_i(cfg_q),
    .status_clr_i(clr_q), .alt_status_clr_i(aclr_q),
    .wake_source_status_o(st), .alt_wake_source_status_o(ast),
    .pin_level_status_o(lv), .bias_o(bias), .irq_o(irq), .wake_req_o(wrq));

  // free running clock, 50 ns period
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // hang guard, well above the roughly 13k cycles the tests need
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      $display("[ERR] %0t run hung", $time);
      tally_and_finish();
    end
  end

  function automatic int lat(input logic slow);
    return slow ? `WKMON_FLT_LONG_CY : `WKMON_FLT_SHORT_CY;
  endfunction

  // expected pull drive per bias code and level
  function automatic logic [5:0] bexp(input logic [1:0] c, input logic [2:0] l);
    case (c)
      2'h1:    return 6'h07;
      2'h2:    return 6'h38;
      2'h3:    return {l, ~l};
      default: return 6'h00;
    endcase
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc_n(input int c);
    repeat (c) @(posedge sys_clk_i);
  endtask

  // count cycles until an irq or wake pulse, at most lim
  task automatic evt(output int c, input int lim);
    c = 0;
    do begin
      @(posedge sys_clk_i);
      c++;
    end while (!(irq === 1'b1 || wrq === 1'b1) && c < lim);
  endtask

  task automatic clr_all;
    @(posedge sys_clk_i);
    clr_q  <= 3'h7;
    aclr_q <= 2'h3;
    @(posedge sys_clk_i);
    clr_q  <= 3'h0;
    aclr_q <= 2'h0;
    cyc_n(2);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    cyc_n(20);
    srst_i <= 1'b0;
    cyc_n(2);
    chk({st, ast, irq, wrq}, 8'h00);
    cfg_q.wake_enable_control <= 3'h7;
    // every mode, both static filters, bounce on the low-power half
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk_i);
      mode_q <= wkmon_mode_t'(m);
      cfg_q.detection_filter_control <= {5'h00, m[0]};
      bnc_q  <= m[1];
      lvl_q[0] <= ~lvl_q[0];
      evt(n, 2000);
      chk(n >= lat(m[0]) && n <= lat(m[0]) + 25, 1);
      chk({irq, wrq}, m < 2 ? 8'h02 : 8'h01);
      cyc_n(40);
      chk(st, 8'h01);
      clr_all();
      chk(st, 8'h00);
    end
    $display("test modes done");
    // a level held just short of the filter time never wakes
    mode_q <= WKMON_MODE_NORMAL;
    bnc_q  <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      @(posedge sys_clk_i);
      cfg_q.detection_filter_control <= {2'h0, 1'b0, j[0], 2'h0};
      lvl_q[1] <= ~lvl_q[1];
      cyc_n(lat(j[0]) - 20);
      lvl_q[1] <= ~lvl_q[1];
      evt(n, 1400);
      chk(st, 8'h00);
    end
    $display("test glitch done");
    // disabled pin: no status, yet its level is readable
    cfg_q <= '{input_bias_control: 6'h00,
               detection_filter_control: 6'h00,
               wake_enable_control: 3'h5};
    @(posedge sys_clk_i);
    lvl_q[1] <= ~lvl_q[1];
    evt(n, 500);
    chk({st, irq}, 8'h00);
    chk(lv[1], lvl_q[1]);
    $display("test enable done");
    // random channel: only its own status bit may set
    cfg_q.wake_enable_control <= 3'h7;
    repeat (6) begin
      rnd = {rnd[15:0], rnd[16] ^ rnd[13]};
      k = rnd % 3;
      @(posedge sys_clk_i);
      lvl_q[k] <= ~lvl_q[k];
      evt(n, 2000);
      cyc_n(2);
      chk(st, 8'h01 << k);
      chk(lv, lvl_q);
      clr_all();
    end
    $display("test random done");
    // clock enable low freezes the pins and the filter
    @(posedge sys_clk_i);
    lvl_q[0] <= ~lvl_q[0];
    ce_i     <= 1'b0;
    cyc_n(100);
    chk({st, irq}, 8'h00);
    ce_i <= 1'b1;
    evt(n, 2000);
    chk(n >= lat(1'b0) && n <= lat(1'b0) + 25, 1);
    cyc_n(2);
    chk(st, 8'h01);
    clr_all();
    $display("test enable hold done");
    // every bias code on all pins
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk_i);
      cfg_q.input_bias_control <= {3{c[1:0]}};
      cyc_n(6);
      chk(bias, bexp(c[1:0], lvl_q));
    end
    $display("test bias done");
    // cyclic pin 2 on timer one then timer two
    for (int j = 0; j < 2; j++) begin
      @(posedge sys_clk_i);
      cfg_q.detection_filter_control <= {j[0] ? 2'h3 : 2'h2, 4'h0};
      cyc_n(2);
      lvl_q[2] <= ~lvl_q[2];
      evt(n, 500);
      chk({st, lv[2]}, {3'h0, ~lvl_q[2]});
      if (j == 0) t1_q <= 1'b1;
      else t2_q <= 1'b1;
      cyc_n(400);
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      cyc_n(10);
      chk(lv[2], lvl_q[2]);
      clr_all();
    end
    $display("test cyclic done");
    // fail pins as wake inputs, then with the role off
    @(posedge sys_clk_i);
    role_q  <= 1'b1;
    fo_q[0] <= 1'b1;
    cyc_n(300);
    chk(ast, 8'h00);
    cyc_n(40);
    chk(ast, 8'h01);
    clr_all();
    role_q  <= 1'b0;
    fo_q[1] <= 1'b1;
    cyc_n(400);
    chk(ast, 8'h00);
    $display("test alt done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
